// [logic/ivp_regs.vh]
// constants for the interrupt vector and priority block
`ifndef IVP_REGS_VH
`define IVP_REGS_VH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define IVP_VEC_W        8
`define IVP_ADDR_W       16
`define IVP_LVL_W        3
`define IVP_NUM_SRC      34
`define IVP_NUM_GRP      13
`define IVP_GRP_W        4

// ---------------------------------------------------------------
// vector numbers
// ---------------------------------------------------------------
`define IVP_VEC_NMI      8'h07
`define IVP_VEC_EXT0     8'h10
`define IVP_VEC_WDT0     8'h19
`define IVP_VEC_ADC      8'h1c
`define IVP_VEC_WDT1     8'h1d
`define IVP_VEC_TPU0     8'h20
`define IVP_VEC_TPU1     8'h28
`define IVP_VEC_TPU2     8'h2c
`define IVP_VEC_SCI0     8'h50
`define IVP_VEC_SCI1     8'h54
`define IVP_VEC_PWM      8'h68
`define IVP_VEC_CAN      8'h6c

// reserved vectors, and the pair lost on the variant without can
`define IVP_VEC_RSV0     8'h16
`define IVP_VEC_RSV1     8'h17
`define IVP_VEC_RSV2     8'h6a
`define IVP_VEC_RSV3     8'h6b
`define IVP_VEC_RSV4     8'h6f
`define IVP_VEC_CAN_LO   8'h6c
`define IVP_VEC_CAN_HI   8'h6d

// ---------------------------------------------------------------
// fixed values
// ---------------------------------------------------------------
`define IVP_NMI_ADDR     16'h001c
`define IVP_NMI_LEVEL    3'h7
`define IVP_ADDR_SHIFT   2

`endif

// [logic/ivp_pick.v]
// default-order priority picker over a vector-sorted source list
`include "ivp_regs.vh"

module ivp_pick #(
   parameter N = `IVP_NUM_SRC
) (
   // candidates, index 0 holds the smallest vector number
   input  wire [N-1:0]              req_in,
   input  wire [N*`IVP_LVL_W-1:0]   lvl_in,
   input  wire [N*`IVP_VEC_W-1:0]   vec_in,
   // winner
   output reg                       found_out,
   output reg  [`IVP_LVL_W-1:0]     lvl_out,
   output reg  [`IVP_VEC_W-1:0]     vec_out
);

   integer i;

   // ---------------------------------------------------------------
   // linear scan
   // ---------------------------------------------------------------
   // strict greater-than keeps the earlier, smaller vector on a tie
   always @* begin
      found_out = 1'b0;
      lvl_out   = {`IVP_LVL_W{1'b0}};
      vec_out   = {`IVP_VEC_W{1'b0}};
      for (i = 0; i < N; i = i + 1) begin
         if (req_in[i] && (!found_out || lvl_in[i*`IVP_LVL_W +: `IVP_LVL_W] > lvl_out)) begin // see RULE_01 RULE_02 RULE_03
            found_out = 1'b1;
            lvl_out   = lvl_in[i*`IVP_LVL_W +: `IVP_LVL_W];
            vec_out   = vec_in[i*`IVP_VEC_W +: `IVP_VEC_W];
         end
      end
   end

endmodule // ivp_pick

// [logic/ivp_ctrl.v]
// interrupt source to vector mapping and priority resolution
//
// Notes on behaviour
// RULE_01 - on equal levels the request with the smaller vector number wins.
// RULE_02 - each peripheral module has a software level that orders modules.
// RULE_03 - modules at the same level are ordered by their default order.
// RULE_04 - sources inside one module share one level and keep a fixed order.
// RULE_05 - the vector address is the low 16 bits of the handler fetch address.
// RULE_06 - the nmi pin uses vector 7 at address 0x001c and beats everything.
// RULE_07 - pins 0 to 5 use vectors 16 to 21 at addresses from 0x0040 by four.
// RULE_08 - vectors 22, 23, 106, 107 and 111 are reserved and never delivered.
// RULE_09 - without the can controller vectors 108 and 109 are never requested.
// RULE_10 - each vector address is four times the vector number.
`include "ivp_regs.vh"

module ivp_ctrl #(
   parameter HAS_CAN = 1
) (
   // clock and reset
   input  wire                                 sys_clk_in,
   input  wire                                 rst_in,
   // mode: 0 fixed default order, 1 programmed levels
   input  wire                                 level_mode_in,
   // one level per module, 3 bits each, group 0 in the low bits
   input  wire [`IVP_NUM_GRP*`IVP_LVL_W-1:0]   priority_level_registers_in,
   // external pin requests, asynchronous
   input  wire                                 nmi_request_in,
   input  wire [5:0]                           ext_request_in,
   // on-chip peripheral requests, same clock
   input  wire                                 watchdog0_overflow_request_in,
   input  wire                                 converter_done_request_in,
   input  wire                                 watchdog1_overflow_request_in,
   input  wire [4:0]                           pulse_timer_unit0_req_in,
   input  wire [3:0]                           pulse_timer_unit1_req_in,
   input  wire [3:0]                           pulse_timer_unit2_req_in,
   input  wire [3:0]                           serial_comm_unit0_req_in,
   input  wire [3:0]                           serial_comm_unit1_req_in,
   input  wire [1:0]                           pwm_req_in,
   input  wire                                 can_error_overrun_request_in,
   input  wire                                 can_mailbox_request_in,
   // winning request toward the cpu core
   output reg                                  irq_valid_out,
   output reg                                  irq_nmi_out,
   output reg  [`IVP_VEC_W-1:0]                irq_vector_out,
   output reg  [`IVP_ADDR_W-1:0]               irq_address_out,
   output reg  [`IVP_LVL_W-1:0]                irq_level_out
);

   localparam NS = `IVP_NUM_SRC;

   // ---------------------------------------------------------------
   // source table
   // ---------------------------------------------------------------
   // sources are listed by rising vector number, so the index order is
   // the fixed default order and the order inside each module
   function [`IVP_VEC_W-1:0] src_vec;
      input integer idx;
      begin
         if (idx < 6)
            src_vec = `IVP_VEC_EXT0 + idx[7:0]; // see RULE_07
         else if (idx == 6)
            src_vec = `IVP_VEC_WDT0;
         else if (idx == 7)
            src_vec = `IVP_VEC_ADC;
         else if (idx == 8)
            src_vec = `IVP_VEC_WDT1;
         else if (idx < 14)
            src_vec = `IVP_VEC_TPU0 + idx[7:0] - 8'h09;
         else if (idx < 18)
            src_vec = `IVP_VEC_TPU1 + idx[7:0] - 8'h0e;
         else if (idx < 22)
            src_vec = `IVP_VEC_TPU2 + idx[7:0] - 8'h12;
         else if (idx < 26)
            src_vec = `IVP_VEC_SCI0 + idx[7:0] - 8'h16;
         else if (idx < 30)
            src_vec = `IVP_VEC_SCI1 + idx[7:0] - 8'h1a;
         else if (idx < 32)
            src_vec = `IVP_VEC_PWM + idx[7:0] - 8'h1e;
         else
            src_vec = `IVP_VEC_CAN + idx[7:0] - 8'h20;
      end
   endfunction

   // which level field governs each source
   function [`IVP_GRP_W-1:0] src_grp;
      input integer idx;
      begin
         case (idx)
            0:       src_grp = 4'h0;
            1:       src_grp = 4'h1;
            2, 3:    src_grp = 4'h2;
            4, 5:    src_grp = 4'h3;
            6:       src_grp = 4'h4;
            7, 8:    src_grp = 4'h5;
            default: begin
               if (idx < 14)
                  src_grp = 4'h6;
               else if (idx < 18)
                  src_grp = 4'h7;
               else if (idx < 22)
                  src_grp = 4'h8;
               else if (idx < 26)
                  src_grp = 4'h9;
               else if (idx < 30)
                  src_grp = 4'ha;
               else if (idx < 32)
                  src_grp = 4'hb;
               else
                  src_grp = 4'hc;
            end
         endcase
      end
   endfunction

   function vec_blocked;
      input [`IVP_VEC_W-1:0] v;
      begin
         vec_blocked = (v == `IVP_VEC_RSV0) || (v == `IVP_VEC_RSV1) ||
                       (v == `IVP_VEC_RSV2) || (v == `IVP_VEC_RSV3) ||
                       (v == `IVP_VEC_RSV4); // see RULE_08
         if (HAS_CAN == 0 && (v == `IVP_VEC_CAN_LO || v == `IVP_VEC_CAN_HI))
            vec_blocked = 1'b1; // see RULE_09
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg  [6:0] pin_meta;
   reg  [6:0] pin_sync;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pin_meta <= 7'h00;
         pin_sync <= 7'h00;
      end else begin
         pin_meta <= {nmi_request_in, ext_request_in};
         pin_sync <= pin_meta;
      end
   end

   wire       nmi_req = pin_sync[6];

   // ---------------------------------------------------------------
   // per-source candidates
   // ---------------------------------------------------------------
   wire [NS-1:0] raw_req = {can_mailbox_request_in, can_error_overrun_request_in,
                            pwm_req_in,
                            serial_comm_unit1_req_in, serial_comm_unit0_req_in,
                            pulse_timer_unit2_req_in, pulse_timer_unit1_req_in,
                            pulse_timer_unit0_req_in,
                            watchdog1_overflow_request_in, converter_done_request_in,
                            watchdog0_overflow_request_in,
                            pin_sync[5:0]};

   wire [NS-1:0]              cand_req;
   wire [NS*`IVP_LVL_W-1:0]   cand_lvl;
   wire [NS*`IVP_VEC_W-1:0]   cand_vec;

   genvar g;
   generate
      for (g = 0; g < NS; g = g + 1) begin : g_src
         assign cand_vec[g*`IVP_VEC_W +: `IVP_VEC_W] = src_vec(g);
         assign cand_req[g] = raw_req[g] & ~vec_blocked(src_vec(g));
         // one field per module; in fixed mode every level reads as zero
         assign cand_lvl[g*`IVP_LVL_W +: `IVP_LVL_W] = level_mode_in ?
            priority_level_registers_in[src_grp(g)*`IVP_LVL_W +: `IVP_LVL_W] :
            {`IVP_LVL_W{1'b0}}; // see RULE_02 RULE_04
      end
   endgenerate

   // ---------------------------------------------------------------
   // arbitration
   // ---------------------------------------------------------------
   wire                    pick_found;
   wire [`IVP_LVL_W-1:0]   pick_lvl;
   wire [`IVP_VEC_W-1:0]   pick_vec;

   ivp_pick #(
      .N         (NS)
   ) u_pick (
      .req_in    (cand_req),
      .lvl_in    (cand_lvl),
      .vec_in    (cand_vec),
      .found_out (pick_found),
      .lvl_out   (pick_lvl),
      .vec_out   (pick_vec)
   );

   // ---------------------------------------------------------------
   // output register
   // ---------------------------------------------------------------
   reg                     next_valid;
   reg                     next_nmi;
   reg  [`IVP_VEC_W-1:0]   next_vec;
   reg  [`IVP_LVL_W-1:0]   next_lvl;

   always @* begin
      if (nmi_req) begin
         // nmi bypasses the level fields entirely
         next_valid = 1'b1; // see RULE_06
         next_nmi   = 1'b1;
         next_vec   = `IVP_VEC_NMI;
         next_lvl   = `IVP_NMI_LEVEL;
      end else begin
         next_valid = pick_found;
         next_nmi   = 1'b0;
         next_vec   = pick_found ? pick_vec : {`IVP_VEC_W{1'b0}};
         next_lvl   = pick_found ? pick_lvl : {`IVP_LVL_W{1'b0}};
      end
   end

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_valid_out   <= 1'b0;
         irq_nmi_out     <= 1'b0;
         irq_vector_out  <= {`IVP_VEC_W{1'b0}};
         irq_address_out <= {`IVP_ADDR_W{1'b0}};
         irq_level_out   <= {`IVP_LVL_W{1'b0}};
      end else begin
         irq_valid_out   <= next_valid;
         irq_nmi_out     <= next_nmi;
         irq_vector_out  <= next_vec;
         // low 16 bits of vector * 4; gives 0x001c for nmi
         irq_address_out <= {{(`IVP_ADDR_W-`IVP_VEC_W-`IVP_ADDR_SHIFT){1'b0}},
                             next_vec, 2'b00}; // see RULE_05 RULE_06 RULE_07 RULE_10
         irq_level_out   <= next_lvl;
      end
   end

endmodule // ivp_ctrl

// [sim/ivp_cpu_model.sv]
// cpu core stand-in that fetches the handler address of each delivered request
module ivp_cpu_model (
   // clock and reset
   input  wire         sys_clk_in,
   input  wire         rst_in,
   // request from the controller
   input  wire         irq_valid_in,
   input  wire  [15:0] irq_address_in,
   // last vector table address fetched
   output logic [15:0] fetch_addr_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // the core only reads the table slot, so nothing but the low 16 bits matter
   always @(posedge sys_clk_in) begin
      if (rst_in)
         fetch_addr_out <= 16'h0000;
      else if (irq_valid_in)
         fetch_addr_out <= irq_address_in;
   end
endmodule // ivp_cpu_model

// [sim/ivp_ctrl_props.sv]
// port assertions for the interrupt vector and priority block
module ivp_ctrl_props #(parameter HAS_CAN = 1) (
   // clock, reset and inputs
   input wire        sys_clk_in,
   input wire        rst_in,
   input wire        level_mode_in,
   input wire        nmi_request_in,
   input wire        converter_done_request_in,
   // winner
   input wire        irq_valid_out,
   input wire        irq_nmi_out,
   input wire [7:0]  irq_vector_out,
   input wire [15:0] irq_address_out,
   input wire [2:0]  irq_level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   AST_ADDR_X4: assert property (
      irq_valid_out && !irq_nmi_out |-> irq_address_out == {6'h00, irq_vector_out, 2'b00})
      else $error("address is not four times the vector");
   AST_NMI_FIXED: assert property (
      irq_nmi_out |-> irq_vector_out == 8'h07 && irq_address_out == 16'h001c
      && irq_level_out == 3'h7) else $error("nmi vector, address or level wrong");
   AST_RESERVED: assert property (
      irq_valid_out |-> !(irq_vector_out inside {8'h16, 8'h17, 8'h6a, 8'h6b, 8'h6f}))
      else $error("reserved vector delivered");
   AST_NO_CAN: assert property (
      HAS_CAN == 0 && irq_valid_out |-> irq_vector_out != 8'h6c && irq_vector_out != 8'h6d)
      else $error("can vector on variant without can");
   AST_NMI_WINS: assert property (
      nmi_request_in[*4] |=> irq_valid_out && irq_nmi_out) else $error("held nmi not delivered");
   AST_MODE0_LEVEL: assert property (
      irq_valid_out && !irq_nmi_out && !$past(level_mode_in) |-> irq_level_out == 3'h0)
      else $error("level not zero in fixed order");
   AST_EXT_ADDR: assert property (
      irq_valid_out && irq_vector_out inside {[8'h10:8'h15]} |->
      irq_address_out == 16'h0040 + 16'(irq_vector_out - 8'h10) * 16'h0004)
      else $error("pin vector address wrong");
   AST_ADC_WINS: assert property (
      $past(converter_done_request_in) && !$past(level_mode_in) && !$past(rst_in)
      && !$past(rst_in, 2) |-> irq_valid_out && irq_vector_out <= 8'h1c)
      else $error("larger vector beat a pending smaller one");
endmodule // ivp_ctrl_props

bind ivp_ctrl ivp_ctrl_props #(.HAS_CAN(HAS_CAN)) u_props (.sys_clk_in(sys_clk_in),
   .rst_in(rst_in), .level_mode_in(level_mode_in), .nmi_request_in(nmi_request_in),
   .converter_done_request_in(converter_done_request_in), .irq_valid_out(irq_valid_out),
   .irq_nmi_out(irq_nmi_out), .irq_vector_out(irq_vector_out),
   .irq_address_out(irq_address_out), .irq_level_out(irq_level_out));

// [sim/interrupt_vector_priority_bench.sv]
// self-checking bench for the interrupt vector and priority block
module interrupt_vector_priority_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        mode = 1'b0;
   logic        nmi = 1'b0;
   logic [38:0] pl = 39'h0;
   logic [33:0] r = 34'h0;
   wire         valid, is_nmi;
   wire [7:0]   vec;
   wire [15:0]  addr, fetch;
   wire [2:0]   lvl;
   wire         nc_valid;
   wire [7:0]   nc_vec;
   int          failures = 0;
   int          compares = 0;
   int          seed = 53;
   int          i;
   ivp_ctrl DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .level_mode_in(mode),
      .priority_level_registers_in(pl), .nmi_request_in(nmi), .ext_request_in(r[5:0]),
      .watchdog0_overflow_request_in(r[6]), .converter_done_request_in(r[7]),
      .watchdog1_overflow_request_in(r[8]), .pulse_timer_unit0_req_in(r[13:9]),
      .pulse_timer_unit1_req_in(r[17:14]), .pulse_timer_unit2_req_in(r[21:18]),
      .serial_comm_unit0_req_in(r[25:22]), .serial_comm_unit1_req_in(r[29:26]),
      .pwm_req_in(r[31:30]), .can_error_overrun_request_in(r[32]),
      .can_mailbox_request_in(r[33]), .irq_valid_out(valid), .irq_nmi_out(is_nmi),
      .irq_vector_out(vec), .irq_address_out(addr), .irq_level_out(lvl));
   ivp_cpu_model CPU (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .irq_valid_in(valid),
      .irq_address_in(addr), .fetch_addr_out(fetch));
   // variant without can: its two can requests must never be delivered
   ivp_ctrl #(.HAS_CAN(0)) DUT_NOCAN (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .level_mode_in(mode), .priority_level_registers_in(pl), .nmi_request_in(nmi),
      .ext_request_in(r[5:0]), .watchdog0_overflow_request_in(r[6]),
      .converter_done_request_in(r[7]), .watchdog1_overflow_request_in(r[8]),
      .pulse_timer_unit0_req_in(r[13:9]), .pulse_timer_unit1_req_in(r[17:14]),
      .pulse_timer_unit2_req_in(r[21:18]), .serial_comm_unit0_req_in(r[25:22]),
      .serial_comm_unit1_req_in(r[29:26]), .pwm_req_in(r[31:30]),
      .can_error_overrun_request_in(r[32]), .can_mailbox_request_in(r[33]),
      .irq_valid_out(nc_valid), .irq_nmi_out(), .irq_vector_out(nc_vec),
      .irq_address_out(), .irq_level_out());
   initial forever #12.5 sys_clk_in = ~sys_clk_in;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // ---------------------------------------------------------------
   // drive, let the pin synchronisers settle, compare with the model
   // ---------------------------------------------------------------
   task automatic run(input logic m, input logic n, input logic [38:0] p, input logic [33:0] q);
      int best, v, b, g, l, best0;
      logic [7:0] ev, ev0;
      mode = m;
      nmi = n;
      pl = p;
      r = q;
      repeat (4) @(posedge sys_clk_in);
      #1;
      best = -1;
      ev = 8'h00;
      best0 = -1;
      ev0 = 8'h00;
      for (v = 16; v < 110; v++) begin
         b = -1;
         g = 0;
         if (v < 22) begin b = v - 16; g = (v < 18) ? b : ((v < 20) ? 2 : 3); end
         else if (v == 25) begin b = 6; g = 4; end
         else if (v == 28 || v == 29) begin b = v - 21; g = 5; end
         else if (v >= 32 && v < 37) begin b = v - 23; g = 6; end
         else if (v >= 40 && v < 48) begin b = v - 26; g = (v < 44) ? 7 : 8; end
         else if (v >= 80 && v < 88) begin b = v - 58; g = (v < 84) ? 9 : 10; end
         else if (v == 104 || v == 105) begin b = v - 74; g = 11; end
         else if (v >= 108) begin b = v - 76; g = 12; end
         l = m ? int'(p[g*3 +: 3]) : 0;
         // strict compare keeps the smaller vector on a tie
         if (b >= 0 && q[b] === 1'b1 && l > best) begin best = l; ev = 8'(v); end
         if (b >= 0 && b < 32 && q[b] === 1'b1 && l > best0) begin best0 = l; ev0 = 8'(v); end
      end
      if (n) begin best = 7; ev = 8'h07; best0 = 7; ev0 = 8'h07; end
      chk("nmi", {15'h0, n}, {15'h0, is_nmi});
      chk("valid_nocan", {15'h0, best0 >= 0}, {15'h0, nc_valid});
      chk("vector_nocan", {8'h00, ev0}, {8'h00, nc_vec});
      chk("valid", {15'h0, best >= 0}, {15'h0, valid});
      chk("vector", {8'h00, ev}, {8'h00, vec});
      chk("address", {6'h00, ev, 2'b00}, addr);
      chk("level", (best > 0) ? 16'(best) : 16'h0, {13'h0, lvl});
      if (best >= 0) chk("fetch", {6'h00, ev, 2'b00}, fetch);
   endtask
   task automatic stop_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100us;
      failures++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge sys_clk_in);
      #1 rst_in = 1'b0;
      run(0, 0, 39'h0, 34'h0);
      run(0, 0, 39'h0, 34'h040000000);
      run(0, 1, 39'h0, 34'h040000000);
      run(0, 0, 39'h0, 34'h040000000);
      for (i = 0; i < 6; i++) run(0, 0, 39'h0, 34'h1 << i);
      run(1, 0, {13{3'h4}}, 34'h3ffffffff);
      run(1, 0, (39'h5 << 33) | 39'h2, 34'h040000001);
      run(1, 0, 39'h6 << 18, 34'h3ffffffff);
      run(1, 1, {13{3'h7}}, 34'h3ffffffff);
      run(1, 0, 39'h7 << 36, 34'h300000000);
      for (i = 0; i < 200; i++)
         run(1'($random(seed)), ($random(seed) % 4) == 0,
            39'({$random(seed), $random(seed)}),
            34'({$random(seed), $random(seed)}) & 34'(33'({$random(seed), $random(seed)})));
      stop_test();
   end
endmodule // interrupt_vector_priority_bench
